// ===== flash_guard_defines.svh
// Offsets, field positions, reset values and key codes of the flash access guard.
// Assumes an 8-bit APB byte address; every register is one aligned 32-bit word.
`ifndef FLASH_GUARD_DEFINES_SVH
`define FLASH_GUARD_DEFINES_SVH

// ==========================================================================
// Register byte addresses
`define FG_CTRL_ADDR      8'h00
`define FG_GUARD_ADDR     8'h04
`define FG_FADDR_ADDR     8'h08
`define FG_FDATA_ADDR     8'h0C
`define FG_OPTION_ADDR    8'h10
`define FG_STATUS_ADDR    8'h14

// ==========================================================================
// Control register fields and reset value
`define FG_CTRL_RESET     8'h00
`define FG_CTRL_PROG      0
`define FG_CTRL_SECT_ERS  1
`define FG_CTRL_MASS_ERS  2
`define FG_CTRL_OPT_WR    3
`define FG_CTRL_SECT_LO   4
`define FG_CTRL_SECT_HI   5

// ==========================================================================
// Guard unlock sequence
`define FG_KEY_FIRST      8'h56
`define FG_KEY_SECOND     8'hAE

// ==========================================================================
// Sector map (16-bit CPU addresses)
`define FG_SECT0_BASE     16'hF000
`define FG_SECT0_TOP      16'hFFFF
`define FG_SECT1_BASE     16'hE000
`define FG_SECT1_TOP      16'hEFFF
`define FG_SECT_BYTES     4096
`define FG_ERASED_BYTE    8'hFF

// ==========================================================================
// Option and status fields
`define FG_OPT_READ_PROT  0
`define FG_OPT_RESET      8'h00
`define FG_ST_MODE_LO     0
`define FG_ST_BUSY        2
`define FG_ST_ARMED       3
`define FG_ST_REFUSED     4
`define FG_ST_TOOL        5
`define FG_ST_LINK_LO     8

`endif

// ===== flash_guard_pkg.sv
// Types used by the flash access guard; its link receiver uses none of them.
// Assumes flash_guard_defines.svh supplies the numeric constants.
package flash_guard_pkg;

    // ======================================================================
    // Programming mode seen by the guard
    typedef enum logic [1:0]
    {
        in_application_programming_mode,
        in_circuit_programming_mode,
        tool_insertion_mode
    } prog_mode_type;

    // ======================================================================
    // Operation sequencer
    typedef enum logic [1:0]
    {
        op_idle,
        op_program,
        op_erase,
        op_option
    } op_state_type;

endpackage

// ===== link_serial_rx.sv
// Serial receiver of the in-circuit link, clocked by the tool's link clock.
// Assumes the tool shifts data MSB first; a toggle marks each complete byte.
`timescale 1ns/1ps

module link_serial_rx
(
    // Link side
    input  wire logic       link_clk,
    input  wire logic       rst_b,
    input  wire logic       data_in,
    // Crossing toward the core
    output logic [7:0]      byte_q,
    output logic            byte_toggle_q
);

    logic [7:0] shift_q;
    logic [2:0] count_q;

    // ======================================================================
    // Shifter: byte_q holds steady until the next byte, for the core to take
    always_ff @(posedge link_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            shift_q       <= 8'h00;
            count_q       <= 3'h0;
            byte_q        <= 8'h00;
            byte_toggle_q <= 1'b0;
        end
        else
        begin
            shift_q <= {shift_q[6:0], data_in};
            count_q <= count_q + 3'h1;
            if (count_q == 3'h7)
            begin
                byte_q        <= {shift_q[6:0], data_in};
                byte_toggle_q <= ~byte_toggle_q;
            end
        end
    end

endmodule

// ===== flash_sector_access_guard.sv
// Sectored program flash with mode-based write protection, read-out
// protection, a keyed command register and an in-circuit link receiver.
// Assumes an APB master on core_clk and a tool-driven link clock.
//
// Function
// - The array erases whole or by sector and programs one byte at a time.
// - Erasing or programming one sector never changes any other sector.
// - The two lowest-numbered sectors are 4 Kbytes each at the top of memory.
// - Sector 0 spans F000h to FFFFh, holding the reset and interrupt vectors.
// - A 4K array has sector 0, an 8K array sectors 0 and 1, larger arrays three.
// - In in-application mode sector 0 refuses write and erase; others accept.
// - Tool and in-circuit modes may program and erase every sector and options.
// - The link uses one serial clock pin and one serial data pin.
// - While the tool is attached the link pins are withheld from the application.
// - Read-out protection blocks external read-out and rewriting of the flash.
// - Clearing read-out protection first erases the whole array automatically.
// - A keyed guard stops stray register writes starting program or erase.
// - The control register resets to 00h and serves programming software.
`timescale 1ns/1ps
`include "flash_guard_defines.svh"

module flash_sector_access_guard
#(
    parameter int FLASH_KB = 16
)
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // In-circuit link pins
    input  wire logic        prog_link_clock_pin,
    input  wire logic        prog_link_data_in,
    output logic             prog_link_data_out,
    output logic             prog_link_data_oe,
    // Mode straps
    input  wire logic        vpp_mode_pin,
    input  wire logic        tool_socket_pin,
    input  wire logic        tool_attached_pin,
    // Application use of the data pin
    input  wire logic        app_data_out,
    input  wire logic        app_data_oe,
    output logic             link_pins_free
);

    localparam int FLASH_BYTES = FLASH_KB * 1024;
    localparam int IDX_W       = $clog2(FLASH_BYTES);
    localparam logic [16:0] BASE17 = 17'h10000 - 17'(FLASH_BYTES);
    localparam logic [15:0] FLASH_BASE = BASE17[15:0];

    // ======================================================================
    // Sector decoding
    function automatic logic [1:0] sector_of(input logic [15:0] a);
        if (a >= `FG_SECT0_BASE)
            sector_of = 2'd0;
        else if (a >= `FG_SECT1_BASE)
            sector_of = 2'd1;
        else
            sector_of = 2'd2;
    endfunction

    function automatic logic sector_exists(input logic [1:0] s);
        if (s == 2'd0)
            sector_exists = 1'b1;
        else if (s == 2'd1)
            sector_exists = (FLASH_BYTES >= 2 * `FG_SECT_BYTES);
        else if (s == 2'd2)
            sector_exists = (FLASH_BYTES > 2 * `FG_SECT_BYTES);
        else
            sector_exists = 1'b0;
    endfunction

    function automatic logic [15:0] sector_base(input logic [1:0] s);
        if (s == 2'd0)
            sector_base = `FG_SECT0_BASE;
        else if (s == 2'd1)
            sector_base = `FG_SECT1_BASE;
        else
            sector_base = FLASH_BASE;
    endfunction

    function automatic logic [15:0] sector_top(input logic [1:0] s);
        if (s == 2'd0)
            sector_top = `FG_SECT0_TOP;
        else if (s == 2'd1)
            sector_top = `FG_SECT1_TOP;
        else
            sector_top = `FG_SECT1_BASE - 16'h0001;
    endfunction

    // ======================================================================
    // Pin synchronisers
    logic [2:0] pin_meta_q;
    logic [2:0] pin_sync_q;
    logic       toggle_meta_q;
    logic       toggle_sync_q;
    logic       toggle_seen_q;
    logic [7:0] link_raw;
    logic       link_toggle;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_meta_q    <= 3'h0;
            pin_sync_q    <= 3'h0;
            toggle_meta_q <= 1'b0;
            toggle_sync_q <= 1'b0;
            toggle_seen_q <= 1'b0;
        end
        else
        begin
            pin_meta_q    <= {tool_attached_pin, tool_socket_pin, vpp_mode_pin};
            pin_sync_q    <= pin_meta_q;
            toggle_meta_q <= link_toggle;
            toggle_sync_q <= toggle_meta_q;
            toggle_seen_q <= toggle_sync_q;
        end
    end

    link_serial_rx u_link_rx
    (
        .link_clk      (prog_link_clock_pin),
        .rst_b         (rst_b),
        .data_in       (prog_link_data_in),
        .byte_q        (link_raw),
        .byte_toggle_q (link_toggle)
    );

    // ======================================================================
    // Mode selection; the tool raises the voltage pin to enter in-circuit mode
    flash_guard_pkg::prog_mode_type mode_q;
    logic tool_attached;

    assign tool_attached = pin_sync_q[2];

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            mode_q <= flash_guard_pkg::in_application_programming_mode;
        else if (pin_sync_q[1])
            mode_q <= flash_guard_pkg::tool_insertion_mode;
        else if (pin_sync_q[0])
            mode_q <= flash_guard_pkg::in_circuit_programming_mode;
        else
            mode_q <= flash_guard_pkg::in_application_programming_mode;
    end

    // ======================================================================
    // Link byte capture; the byte changes on the same link edge as its toggle and has settled two core edges before capture
    logic [7:0] link_byte_q;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            link_byte_q <= 8'h00;
        else if (toggle_sync_q != toggle_seen_q)
            link_byte_q <= link_raw;
    end

    // ======================================================================
    // Data pin ownership: an attached tool owns the pin even when idle
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prog_link_data_out <= 1'b0;
            prog_link_data_oe  <= 1'b0;
            link_pins_free     <= 1'b0;
        end
        else
        begin
            prog_link_data_out <= app_data_out;
            prog_link_data_oe  <= app_data_oe & ~tool_attached;
            link_pins_free     <= ~tool_attached;
        end
    end

    // ======================================================================
    // APB handshake: no wait states, pready from a flop
    logic       wr_take;
    logic       rd_take;
    logic       addr_ok;

    assign addr_ok = (paddr == `FG_CTRL_ADDR)  || (paddr == `FG_GUARD_ADDR)  ||
                     (paddr == `FG_FADDR_ADDR) || (paddr == `FG_FDATA_ADDR)  ||
                     (paddr == `FG_OPTION_ADDR) || (paddr == `FG_STATUS_ADDR);
    assign wr_take = psel & penable & pready & pwrite & addr_ok;
    assign rd_take = psel & ~penable & ~pwrite;

    // ======================================================================
    // Software registers
    logic [7:0]  ctrl_q;
    logic [15:0] faddr_q;
    logic [7:0]  fdata_q;
    logic [7:0]  option_q;
    logic        key_half_q;
    logic        armed_q;
    logic        refused_q;
    logic        start;
    logic        refuse;
    logic        read_prot;
    logic        privileged;
    flash_guard_pkg::op_state_type state_q;

    assign read_prot  = option_q[`FG_OPT_READ_PROT];
    assign privileged = (mode_q != flash_guard_pkg::in_application_programming_mode);
    assign start      = wr_take && (paddr == `FG_CTRL_ADDR) && armed_q &&
                        (state_q == flash_guard_pkg::op_idle);

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            faddr_q  <= 16'h0000;
            fdata_q  <= 8'h00;
        end
        else if (wr_take && paddr == `FG_FADDR_ADDR)
            faddr_q <= pwdata[15:0];
        else if (wr_take && paddr == `FG_FDATA_ADDR)
            fdata_q <= pwdata[7:0];
    end

    // Guard: two key writes arm a single command; any other guard write disarms
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            key_half_q <= 1'b0;
            armed_q    <= 1'b0;
        end
        else if (wr_take && paddr == `FG_GUARD_ADDR)
        begin
            key_half_q <= (pwdata[7:0] == `FG_KEY_FIRST);
            armed_q    <= key_half_q && (pwdata[7:0] == `FG_KEY_SECOND);
        end
        else if (wr_take && paddr == `FG_CTRL_ADDR)
        begin
            key_half_q <= 1'b0;
            armed_q    <= 1'b0;
        end
    end

    // ======================================================================
    // Command decode and protection checks
    logic [1:0]  req_sect;
    logic        is_prog;
    logic        is_sect;
    logic        is_mass;
    logic        is_opt;
    logic        addr_in;

    assign is_prog  = pwdata[`FG_CTRL_PROG];
    assign is_sect  = pwdata[`FG_CTRL_SECT_ERS];
    assign is_mass  = pwdata[`FG_CTRL_MASS_ERS];
    assign is_opt   = pwdata[`FG_CTRL_OPT_WR];
    assign req_sect = is_prog ? sector_of(faddr_q) : pwdata[`FG_CTRL_SECT_HI:`FG_CTRL_SECT_LO];
    assign addr_in  = (faddr_q >= FLASH_BASE);

    always_comb
    begin
        refuse = 1'b0;
        if (is_opt)
            refuse = ~privileged;
        else if (is_mass)
            refuse = ~privileged;
        else if (is_prog || is_sect)
        begin
            if (read_prot)
                refuse = 1'b1;
            else if (!sector_exists(req_sect) || (is_prog && !addr_in))
                refuse = 1'b1;
            else if (!privileged && req_sect == 2'd0)
                refuse = 1'b1;
        end
    end

    // Control register keeps the last accepted command until it completes
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            ctrl_q <= `FG_CTRL_RESET;
        else if (start && !refuse)
            ctrl_q <= pwdata[7:0];
        else if (state_q == flash_guard_pkg::op_idle)
            ctrl_q <= `FG_CTRL_RESET;
    end

    // ======================================================================
    // Sequencer: erase walks its range one byte a cycle
    logic [IDX_W-1:0] ptr_q;
    logic [IDX_W-1:0] last_q;
    logic             unprotect_q;
    logic [IDX_W-1:0] sect_lo;
    logic [IDX_W-1:0] sect_hi;
    logic [IDX_W-1:0] prog_idx;
    logic [15:0]      off_lo;
    logic [15:0]      off_hi;
    logic [15:0]      off_pg;

    assign off_lo   = sector_base(req_sect) - FLASH_BASE;
    assign off_hi   = sector_top(req_sect) - FLASH_BASE;
    assign off_pg   = faddr_q - FLASH_BASE;
    assign sect_lo  = off_lo[IDX_W-1:0];
    assign sect_hi  = off_hi[IDX_W-1:0];
    assign prog_idx = off_pg[IDX_W-1:0];

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q     <= flash_guard_pkg::op_idle;
            ptr_q       <= '0;
            last_q      <= '0;
            unprotect_q <= 1'b0;
            option_q    <= `FG_OPT_RESET;
        end
        else
        begin
            case (state_q)
                flash_guard_pkg::op_idle:
                begin
                    if (start && !refuse)
                    begin
                        if (is_opt && read_prot && !fdata_q[`FG_OPT_READ_PROT])
                        begin
                            ptr_q       <= '0;
                            last_q      <= IDX_W'(FLASH_BYTES - 1);
                            unprotect_q <= 1'b1;
                            state_q     <= flash_guard_pkg::op_erase;
                        end
                        else if (is_opt)
                            state_q <= flash_guard_pkg::op_option;
                        else if (is_mass)
                        begin
                            ptr_q   <= '0;
                            last_q  <= IDX_W'(FLASH_BYTES - 1);
                            state_q <= flash_guard_pkg::op_erase;
                        end
                        else if (is_sect)
                        begin
                            ptr_q   <= sect_lo;
                            last_q  <= sect_hi;
                            state_q <= flash_guard_pkg::op_erase;
                        end
                        else if (is_prog)
                        begin
                            ptr_q   <= prog_idx;
                            state_q <= flash_guard_pkg::op_program;
                        end
                    end
                end
                flash_guard_pkg::op_program:
                    state_q <= flash_guard_pkg::op_idle;
                flash_guard_pkg::op_erase:
                begin
                    ptr_q <= ptr_q + IDX_W'(1);
                    if (ptr_q == last_q)
                    begin
                        if (unprotect_q)
                        begin
                            option_q[`FG_OPT_READ_PROT] <= 1'b0;
                            unprotect_q                 <= 1'b0;
                        end
                        state_q <= flash_guard_pkg::op_idle;
                    end
                end
                flash_guard_pkg::op_option:
                begin
                    option_q <= fdata_q;
                    state_q  <= flash_guard_pkg::op_idle;
                end
                default:
                    state_q <= flash_guard_pkg::op_idle;
            endcase
        end
    end

    // Refusals are sticky; a new refusal wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            refused_q <= 1'b0;
        else if (start && refuse)
            refused_q <= 1'b1;
        else if (wr_take && paddr == `FG_STATUS_ADDR && pwdata[`FG_ST_REFUSED])
            refused_q <= 1'b0;
    end

    // ======================================================================
    // Flash array; only the sequencer writes it
    logic [7:0] mem [FLASH_BYTES];

    always_ff @(posedge core_clk)
    begin
        if (state_q == flash_guard_pkg::op_erase)
            mem[ptr_q] <= `FG_ERASED_BYTE;
        else if (state_q == flash_guard_pkg::op_program)
            mem[ptr_q] <= mem[ptr_q] & fdata_q;
    end

    // ======================================================================
    // Read path; protected flash reads as zero from the tool side
    logic [31:0] rd_word;
    logic [7:0]  flash_rd;

    always_comb
    begin
        flash_rd = 8'h00;
        if (addr_in && !(read_prot && privileged))
            flash_rd = mem[prog_idx];
    end

    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (paddr)
            `FG_CTRL_ADDR:   rd_word = {24'h000000, ctrl_q};
            `FG_FADDR_ADDR:  rd_word = {16'h0000, faddr_q};
            `FG_FDATA_ADDR:  rd_word = {24'h000000, flash_rd};
            `FG_OPTION_ADDR: rd_word = {24'h000000, option_q};
            `FG_STATUS_ADDR: rd_word = {16'h0000, link_byte_q, 2'b00, tool_attached,
                                        refused_q, armed_q,
                                        state_q != flash_guard_pkg::op_idle, mode_q};
            default:         rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel & ~penable & ~pready;
            pslverr <= psel & ~penable & ~addr_ok;
            if (rd_take)
                prdata <= rd_word;
        end
    end

endmodule

// ===== link_tool_model.sv
// Tool end of the in-circuit link: makes the link clock and serial data.
// Assumes the receiver samples data on the rising link clock edge.
`timescale 1ns/1ps
module link_tool_model
(
    // Link pins
    output logic clk_pin,
    output logic data_pin
);
    // ====
    // Byte frame
    // Clock stands still between bytes; data then shows the inverse bit
    initial
    begin
        clk_pin = 1'b0;
        data_pin = 1'b1;
    end
    task automatic send(input logic [7:0] b);
        #1.3;
        for (int i = 7; i >= 0; i--)
        begin
            data_pin = b[i];
            #3 clk_pin = 1'b1;
            #3 clk_pin = 1'b0;
        end
        data_pin = ~b[0];
    endtask
endmodule

// ===== flash_guard_checker.sv
// Port checker for the flash access guard, bound into its top module.
// Assumes every checked signal lives in the core clock domain.
`timescale 1ns/1ps
module flash_guard_checker
(
    // Observed ports
    input wire logic       core_clk,
    input wire logic       rst_b,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       tool_attached_pin,
    input wire logic       app_data_out,
    input wire logic       prog_link_data_out,
    input wire logic       prog_link_data_oe,
    input wire logic       link_pins_free
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    logic setup;
    logic mapped;
    assign setup = psel && !penable;
    assign mapped = (paddr <= 8'h14) && (paddr[1:0] == 2'b00);
    // ====
    // Bus answer
    AST_READY_AFTER_SETUP: assert property (setup |=> pready)
        else $error("no answer after setup");
    AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
        else $error("answer held too long");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("error without answer");
    AST_UNMAPPED_ERR: assert property (setup && !mapped |=> pslverr)
        else $error("unmapped access not refused");
    AST_MAPPED_OK: assert property (setup && mapped |=> !pslverr)
        else $error("mapped access refused");
    // ====
    // Link pins; three edges of sync delay are allowed for
    AST_TOOL_NO_DRIVE: assert property (tool_attached_pin [*4] |->
        !prog_link_data_oe && !link_pins_free)
        else $error("pins used while tool attached");
    AST_FREE_NO_TOOL: assert property (!tool_attached_pin [*5] |-> link_pins_free)
        else $error("pins withheld without tool");
    AST_APP_DATA_COPY: assert property (!tool_attached_pin [*5] |->
        prog_link_data_out == $past(app_data_out))
        else $error("application data not passed");
    cover property (setup && !mapped);
    cover property (tool_attached_pin [*8]);
    cover property (setup && paddr == 8'h00);
endmodule
bind flash_sector_access_guard flash_guard_checker flash_guard_checker_inst
    (.core_clk, .rst_b, .psel, .penable, .paddr, .pready, .pslverr, .tool_attached_pin,
    .app_data_out, .prog_link_data_out, .prog_link_data_oe, .link_pins_free);

// ===== tb_flash_sector_access_guard.sv
// Self-checking bench: APB master, link tool model, read-data scoreboard.
// Assumes the default 16K array and the checker bound in its own file.
`timescale 1ns/1ps
`include "flash_guard_defines.svh"
module tb_flash_sector_access_guard;
    logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic lclk, ldat, dout, doe, vpp, sock, att, aout, aoe, pfree;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  paddr, lb;
    logic [7:0]  bv[3];
    logic [15:0] ad[3];
    logic [63:0] expq[$];
    int          fail_count = 0;
    int          total_checks = 0;
    flash_sector_access_guard flash_sector_access_guard_inst (.core_clk, .rst_b, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .prog_link_clock_pin(lclk), .prog_link_data_in(ldat), .prog_link_data_out(dout),
        .prog_link_data_oe(doe), .vpp_mode_pin(vpp), .tool_socket_pin(sock),
        .tool_attached_pin(att), .app_data_out(aout), .app_data_oe(aoe),
        .link_pins_free(pfree));
    link_tool_model link_tool_model_inst (.clk_pin(lclk), .data_pin(ldat));
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        aout <= $urandom;
        aoe <= $urandom;
    end
    // ====
    // Scoreboard: only reads with a queued note are compared
    always @(posedge core_clk)
        if (psel && penable && pready && !pwrite && expq.size() > 0)
            check_rd(expq.pop_front());
    task automatic check_rd(input logic [63:0] e);
        total_checks++;
        if ((prdata & e[63:32]) !== e[31:0])
        begin
            fail_count++;
            $display("ERROR %0t read %h expected %h", $time, prdata, e[31:0]);
        end
    endtask
    // ====
    // Bus tasks; an idle cycle between transfers keeps one assignment per step
    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
        expq.push_back({m, e});
        apb(1'b0, a, 16'h0);
    endtask
    task automatic rdm(input logic [15:0] a, input logic [7:0] e);
        wr(`FG_FADDR_ADDR, a);
        chk(`FG_FDATA_ADDR, {24'h0, e});
    endtask
    task automatic cmd(input logic [7:0] c);
        wr(`FG_GUARD_ADDR, {8'h0, `FG_KEY_FIRST});
        wr(`FG_GUARD_ADDR, {8'h0, `FG_KEY_SECOND});
        wr(`FG_CTRL_ADDR, {8'h0, c});
        do
            apb(1'b0, `FG_STATUS_ADDR, 16'h0);
        while (rd[`FG_ST_BUSY] !== 1'b0);
    endtask
    task automatic prog(input logic [15:0] a, input logic [7:0] d);
        wr(`FG_FADDR_ADDR, a);
        wr(`FG_FDATA_ADDR, {8'h0, d});
        cmd(8'h01);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ====
    // Run of about 37k cycles; the watchdog allows 0.7 ms
    initial
    begin
        #700000;
        fail_count++;
        close_out();
    end
    initial
    begin
        void'($urandom(32'h4997D63B));
        {psel, penable, pwrite, paddr, pwdata, vpp, sock, att} = '0;
        ad = '{16'hF000, 16'hEFFF, 16'hDFFF};
        rst_b = 1'b0;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        chk(`FG_CTRL_ADDR, 32'h0);
        chk(`FG_OPTION_ADDR, 32'h0);
        chk(`FG_STATUS_ADDR, 32'h0);
        chk(8'h40, 32'h0);
        vpp <= 1'b1;
        cmd(8'h04);
        rdm(16'hF000, 8'hFF);
        wr(`FG_FDATA_ADDR, 16'h0);
        wr(`FG_CTRL_ADDR, 16'h1);
        chk(`FG_FDATA_ADDR, 32'hFF);
        rdm(16'hBFFF, 8'h00);
        for (int s = 0; s < 3; s++)
        begin
            bv[s] = $urandom;
            prog(ad[s], bv[s]);
            rdm(ad[s], bv[s]);
        end
        cmd(8'h12);
        rdm(ad[1], 8'hFF);
        rdm(ad[0], bv[0]);
        rdm(ad[2], bv[2]);
        vpp <= 1'b0;
        prog(ad[0], 8'h00);
        chk(`FG_STATUS_ADDR, 32'h10, 32'h1F);
        rdm(ad[0], bv[0]);
        wr(`FG_STATUS_ADDR, 16'h10);
        cmd(8'h02);
        chk(`FG_STATUS_ADDR, 32'h10, 32'h1F);
        prog(ad[1], bv[1]);
        rdm(ad[0], bv[0]);
        rdm(ad[1], bv[1]);
        vpp <= 1'b1;
        wr(`FG_FDATA_ADDR, 16'h01);
        cmd(8'h08);
        chk(`FG_OPTION_ADDR, 32'h1);
        wr(`FG_STATUS_ADDR, 16'h10);
        prog(ad[2], 8'h00);
        chk(`FG_STATUS_ADDR, 32'h11, 32'h1F);
        rdm(ad[1], 8'h00);
        wr(`FG_FDATA_ADDR, 16'h00);
        cmd(8'h08);
        chk(`FG_OPTION_ADDR, 32'h0);
        rdm(ad[2], 8'hFF);
        rdm(ad[1], 8'hFF);
        wr(`FG_STATUS_ADDR, 16'h10);
        sock <= 1'b1;
        att <= 1'b1;
        lb = $urandom;
        prog(ad[0], 8'h00);
        link_tool_model_inst.send(lb);
        repeat (5) @(posedge core_clk);
        chk(`FG_STATUS_ADDR, {16'h0, lb, 8'h22}, 32'hFF3F);
        rdm(ad[0], 8'h00);
        close_out();
    end
endmodule
